// ===== rtl/pls_pkg.sv
/*
 * Shared constants and types for the two-port latch block with LED scan.
 * Assumes a 32-bit APB bus on mclk, byte addresses, one register per word.
 */
package pls_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_P0_DATA = 8'h00;
  localparam logic [7:0] OFS_P1_DATA = 8'h04;
  localparam logic [7:0] OFS_P0_ANA  = 8'h08;
  localparam logic [7:0] OFS_P1_ANA  = 8'h0C;
  localparam logic [7:0] OFS_P0_MODE = 8'h10;
  localparam logic [7:0] OFS_P1_MODE = 8'h14;
  localparam logic [7:0] OFS_P0_DIR  = 8'h18;
  localparam logic [7:0] OFS_P1_DIR  = 8'h1C;
  localparam logic [7:0] OFS_BITOP   = 8'h20;
  localparam logic [7:0] OFS_DISP    = 8'h24;
  localparam logic [7:0] OFS_SCAN    = 8'h28;
  localparam logic [7:0] OFS_PAT0    = 8'h30;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIR   = 8'hFF;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam int         BOP_PORT  = 3;
  localparam int         BOP_VAL   = 4;
  localparam int         DISP_EN   = 0;

  // Pins with open-drain capability per port
  localparam logic [7:0] PCH_MASK0 = 8'h3F;
  localparam logic [7:0] NCH_MASK0 = 8'hC0;
  localparam logic [7:0] NCH_MASK1 = 8'h3F;

  // ----------------------------------------------------------------
  // Display geometry; pattern bit set means segment lit
  // ----------------------------------------------------------------
  localparam int         NUM_DIGITS = 6;
  localparam logic [2:0] LAST_DIGIT = 3'h5;
  localparam int         SEG_A  = 0;
  localparam int         SEG_G  = 6;
  localparam int         SEG_DP = 7;
  localparam int         DP_PIN = 6;
  localparam int         G_PIN  = 7;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } pls_pad_t;

  typedef enum logic {SCAN_IDLE, SCAN_RUN} pls_scan_t;

endpackage

// ===== rtl/pls_digit_scan.sv
/*
 * Digit sequencer for the multiplexed six-digit display.
 * Assumes the interval event is a one-cycle pulse on mclk.
 */
`timescale 1ns/1ps
module pls_digit_scan import pls_pkg::*; (
  input  wire logic       mclk,     // System clock
  input  wire logic       rst_b,    // Async reset, active low
  input  wire logic       enable,   // Scanning allowed
  input  wire logic       tick,     // Interval event pulse
  output logic [2:0]      digitIdx, // Digit of the current scan step, LAST_DIGIT from the second idle cycle on (reset loads 0)
  output logic            loadNow   // Pulse: load latches
);

  pls_scan_t  state_q, state_d;
  logic [2:0] digit_q, digit_d;
  logic       load_q, load_d;

  always_comb begin
    state_d = state_q;
    digit_d = digit_q;
    load_d  = 1'b0;
    case (state_q)
      SCAN_IDLE: begin
        // Start on the last digit so the first event shows digit 0
        digit_d = LAST_DIGIT;
        if (enable) begin
          state_d = SCAN_RUN;
        end
      end
      SCAN_RUN: begin
        if (!enable) begin
          state_d = SCAN_IDLE;
        end else if (tick) begin
          digit_d = (digit_q == LAST_DIGIT) ? 3'h0 : digit_q + 3'h1;
          load_d  = 1'b1;
        end
      end
      default: state_d = SCAN_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SCAN_IDLE;
      digit_q <= 3'h0;
      load_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      digit_q <= digit_d;
      load_q  <= load_d;
    end
  end

  assign digitIdx = digit_q;
  assign loadNow  = load_q;

  chk_scan_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q == SCAN_RUN && enable && tick && digit_q == LAST_DIGIT)
      |=> (digit_q == 3'h0 && load_q)) else $error("digit scan did not wrap to 0");

endmodule

// ===== rtl/pls_port_latch.sv
/*
 * Two 8-bit digital ports with APB registers and a six-digit LED scan.
 * Assumes pin inputs are asynchronous and the pads resolve dout/oe.
 */
`timescale 1ns/1ps

module pls_port_latch import pls_pkg::*; (
  input  wire logic        mclk,         // System clock, 20 MHz
  input  wire logic        rst_b,        // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB write
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  input  wire logic        intervalTick, // Interval timer event pulse
  input  wire logic [7:0]  port0PinIn,   // Port 0 pin levels
  input  wire logic [7:0]  port1PinIn,   // Port 1 pin levels
  output pls_pad_t         port0Drive,   // Port 0 pad out and enable
  output pls_pad_t         port1Drive    // Port 1 pad out and enable
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] readView(input logic [7:0] latch, pin, dir, ana);
    // Analog pins have no digital input path and read as zero
    readView = ((dir & pin) | (~dir & latch)) & ~ana;
  endfunction

  function automatic pls_pad_t padDrive(input logic [7:0] latch, dir, ana, mode,
                                        input logic [7:0] pch, nch);
    logic [7:0] act;
    act = ~dir & ~ana;
    padDrive.dout = (latch & ~(mode & nch)) | (mode & pch);
    padDrive.oe   = act & ((~mode | ~(pch | nch)) // push-pull
                         | (mode & pch & latch)
                         | (mode & nch & ~latch));
  endfunction

  function automatic logic patHit(input logic [7:0] addr);
    patHit = addr >= OFS_PAT0 && addr < OFS_PAT0 + 8'(4 * NUM_DIGITS) && addr[1:0] == 2'h0;
  endfunction

  function automatic logic [2:0] patIdx(input logic [7:0] addr);
    logic [7:0] off;
    off    = addr - OFS_PAT0;
    patIdx = off[4:2];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0][7:0] pinMeta_q;
  logic [1:0][7:0] pinSync_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= {port1PinIn, port0PinIn};
      pinSync_q <= pinMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [1:0][7:0] latch_q, latch_d;
  logic [1:0][7:0] ana_q, ana_d;
  logic [1:0][7:0] mode_q, mode_d;
  logic [1:0][7:0] dir_q, dir_d;
  logic [7:0]      pat_q [NUM_DIGITS];
  logic [7:0]      pat_d [NUM_DIGITS];
  logic            dispEn_q, dispEn_d;
  logic            pready_q, pready_d;
  logic            pslverr_q, pslverr_d;
  logic [31:0]     prdata_q, prdata_d;
  logic [1:0][7:0] rdView;
  logic [2:0]      digitIdx;
  logic            scanLoad;
  logic [7:0]      curPat;
  logic            wrEn;
  logic [7:0]      bitTmp;

  assign wrEn   = psel && penable && pready_q && pwrite;
  assign curPat = pat_q[digitIdx];

  for (genvar p = 0; p < 2; p++) begin : g_view
    assign rdView[p] = readView(latch_q[p], pinSync_q[p], dir_q[p], ana_q[p]);
  end

  pls_digit_scan u_scan (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .enable   (dispEn_q),
    .tick     (intervalTick),
    .digitIdx (digitIdx),
    .loadNow  (scanLoad)
  );

  always_comb begin
    latch_d  = latch_q;
    ana_d    = ana_q;
    mode_d   = mode_q;
    dir_d    = dir_q;
    pat_d    = pat_q;
    dispEn_d = dispEn_q;
    bitTmp   = 8'h00;
    if (scanLoad) begin
      // One digit high at a time, lit segments driven low
      latch_d[0][5:0]    = 6'(6'h01 << digitIdx);
      latch_d[0][DP_PIN] = ~curPat[SEG_DP];
      latch_d[0][G_PIN]  = ~curPat[SEG_G];
      for (int k = 0; k < 6; k++) begin
        latch_d[1][k] = ~curPat[5 - k];
      end
    end
    // A software write in the same cycle wins over the scan load
    if (wrEn) begin
      case (paddr)
        OFS_P0_DATA: latch_d[0] = pwdata[7:0];
        OFS_P1_DATA: latch_d[1] = pwdata[7:0];
        OFS_P0_ANA:  ana_d[0]   = pwdata[7:0];
        OFS_P1_ANA:  ana_d[1]   = pwdata[7:0];
        OFS_P0_MODE: mode_d[0]  = pwdata[7:0];
        OFS_P1_MODE: mode_d[1]  = pwdata[7:0];
        OFS_P0_DIR:  dir_d[0]   = pwdata[7:0];
        OFS_P1_DIR:  dir_d[1]   = pwdata[7:0];
        OFS_BITOP: begin
          // Whole-port read, one bit changed, whole-port write back
          bitTmp                    = rdView[pwdata[BOP_PORT]];
          bitTmp[pwdata[2:0]]       = pwdata[BOP_VAL];
          latch_d[pwdata[BOP_PORT]] = bitTmp;
        end
        OFS_DISP: dispEn_d = pwdata[DISP_EN];
        default: begin
          if (patHit(paddr)) begin
            pat_d[patIdx(paddr)] = pwdata[7:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q  <= '0;
      ana_q    <= '0;
      mode_q   <= '0;
      dir_q    <= {RST_DIR, RST_DIR};
      dispEn_q <= 1'b0;
      for (int i = 0; i < NUM_DIGITS; i++) begin
        pat_q[i] <= RST_ZERO;
      end
    end else begin
      latch_q  <= latch_d;
      ana_q    <= ana_d;
      mode_q   <= mode_d;
      dir_q    <= dir_d;
      dispEn_q <= dispEn_d;
      pat_q    <= pat_d;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: read data taken in setup, write and ready in first access cycle
  // ----------------------------------------------------------------
  always_comb begin
    pready_d  = psel && !penable;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (psel && !penable) begin
      case (paddr)
        OFS_P0_DATA: prdata_d[7:0] = rdView[0];
        OFS_P1_DATA: prdata_d[7:0] = rdView[1];
        OFS_P0_ANA:  prdata_d[7:0] = ana_q[0];
        OFS_P1_ANA:  prdata_d[7:0] = ana_q[1];
        OFS_P0_MODE: prdata_d[7:0] = mode_q[0];
        OFS_P1_MODE: prdata_d[7:0] = mode_q[1];
        OFS_P0_DIR:  prdata_d[7:0] = dir_q[0];
        OFS_P1_DIR:  prdata_d[7:0] = dir_q[1];
        OFS_BITOP:   prdata_d      = 32'h0000_0000;
        OFS_DISP:    prdata_d[DISP_EN] = dispEn_q;
        OFS_SCAN:    prdata_d[2:0] = digitIdx;
        default: begin
          if (patHit(paddr)) begin
            prdata_d[7:0] = pat_q[patIdx(paddr)];
          end else begin
            pslverr_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // Pad drive, registered so pins never see decode glitches
  // ----------------------------------------------------------------
  pls_pad_t pad0_q, pad0_d, pad1_q, pad1_d;

  always_comb begin
    pad0_d = padDrive(latch_q[0], dir_q[0], ana_q[0], mode_q[0], PCH_MASK0, NCH_MASK0);
    pad1_d = padDrive(latch_q[1], dir_q[1], ana_q[1], mode_q[1], RST_ZERO, NCH_MASK1);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pad0_q <= '0;
      pad1_q <= '0;
    end else begin
      pad0_q <= pad0_d;
      pad1_q <= pad1_d;
    end
  end

  assign port0Drive = pad0_q;
  assign port1Drive = pad1_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic rdP0Acc;
  assign rdP0Acc = psel && penable && pready && !pwrite && paddr == OFS_P0_DATA;

  chk_rd_input_pin: assert property (rdP0Acc |->
    ((prdata[7:0] ^ $past(pinSync_q[0])) & $past(dir_q[0]) & ~$past(ana_q[0])) == 8'h00)
    else $error("input bit did not read the pin");
  chk_rd_output_latch: assert property (rdP0Acc |->
    ((prdata[7:0] ^ $past(latch_q[0])) & ~$past(dir_q[0]) & ~$past(ana_q[0])) == 8'h00)
    else $error("output bit did not read the latch");
  chk_bitop_target: assert property ((wrEn && paddr == OFS_BITOP) |=>
    latch_q[$past(pwdata[BOP_PORT])][$past(pwdata[2:0])] == $past(pwdata[BOP_VAL]))
    else $error("single-bit write missed its bit");
  chk_bitop_others: assert property ((wrEn && paddr == OFS_BITOP && !pwdata[BOP_PORT]) |=>
    ((latch_q[0] ^ $past(rdView[0])) & ~(8'h01 << $past(pwdata[2:0]))) == 8'h00)
    else $error("untouched bits not loaded from read view");
  chk_analog_off: assert property ((port0Drive.oe & $past(ana_q[0])) == 8'h00)
    else $error("analog pin drives digitally");
  chk_input_hiz: assert property ((port1Drive.oe & $past(dir_q[1])) == 8'h00)
    else $error("input pin buffer enabled");
  chk_pch_no_low: assert property
    ((port0Drive.oe & ~port0Drive.dout & $past(mode_q[0]) & PCH_MASK0) == 8'h00)
    else $error("p-channel open drain drove low");
  chk_nch_no_high: assert property
    ((port1Drive.oe & port1Drive.dout & $past(mode_q[1]) & NCH_MASK1) == 8'h00)
    else $error("n-channel open drain drove high");
  // Pads follow the registers one edge later, so compare against last cycle's state
  chk_output_drive: assert property
    ((port1Drive.oe == ~($past(dir_q[1]) | $past(ana_q[1])))
      || $past(mode_q[1]) != 8'h00) else $error("push-pull output not enabled");
  chk_digit_onehot: assert property ((scanLoad && !wrEn) |=>
    latch_q[0][5:0] == 6'(6'h01 << $past(digitIdx))) else $error("digit select not one-hot");
  chk_seg_map: assert property ((scanLoad && !wrEn) |=>
    latch_q[1][0] == !$past(curPat[5]) && latch_q[1][5] == !$past(curPat[SEG_A])
    && latch_q[0][DP_PIN] == !$past(curPat[SEG_DP])) else $error("segment map wrong");
  chk_lit_pair: assert property ((scanLoad && !wrEn && curPat[SEG_G]) |=>
    latch_q[0][$past(digitIdx)] && !latch_q[0][G_PIN])
    else $error("lit segment not high/low pair");

endmodule

// ===== verification/pls_led_model.sv
/*
 * Model of the six-digit, eight-segment LED wired to both ports.
 * Assumes pad dout/oe from the port block; the bench may drive pins as an outside source.
 */
`timescale 1ns/1ps
module pls_led_model import pls_pkg::*; (
  input  wire pls_pad_t    port0Drive, // Port 0 pads
  input  wire pls_pad_t    port1Drive, // Port 1 pads
  input  wire logic [15:0] extEn,      // Outside driver enables, port 1 high
  input  wire logic [15:0] extVal,     // Outside driver levels
  output logic      [7:0]  pin0,       // Port 0 wire levels
  output logic      [7:0]  pin1,       // Port 1 wire levels
  output logic      [47:0] litMap      // Lit segments, eight per digit
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Digit lines sink through the display, segment lines are pulled up
  localparam logic [15:0] PULL = 16'hFFC0;
  logic [15:0] drvOut;
  logic [15:0] drvEn;
  logic [15:0] lvl;
  logic [7:0]  segOn;
  assign drvOut = {port1Drive.dout, port0Drive.dout};
  assign drvEn  = {port1Drive.oe, port0Drive.oe};
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      lvl[i] = extEn[i] ? extVal[i] : (drvEn[i] ? drvOut[i] : PULL[i]);
    end
  end
  assign pin0 = lvl[7:0];
  assign pin1 = lvl[15:8];
  // ----------------------------------------------------------------
  // Segment map: bit0 a .. bit6 g, bit7 dp; a low line sinks current
  // ----------------------------------------------------------------
  assign segOn = ~{lvl[6], lvl[7], lvl[8], lvl[9], lvl[10], lvl[11], lvl[12], lvl[13]};
  always_comb begin
    for (int d = 0; d < 6; d++) begin
      litMap[d*8 +: 8] = lvl[d] ? segOn : 8'h00;
    end
  end
endmodule

// ===== verification/port_latch_led_scan_test.sv
/*
 * Self-checking bench for the two-port latch block with LED scan.
 * Assumes the LED model in its own file and zero-wait APB answers.
 */
`timescale 1ns/1ps
module port_latch_led_scan_test import pls_pkg::*;;
  logic        mclk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        intervalTick;
  logic [15:0] extEn;
  logic [15:0] extVal;
  logic [7:0]  pin0;
  logic [7:0]  pin1;
  logic [47:0] litMap;
  pls_pad_t    port0Drive;
  pls_pad_t    port1Drive;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          checks;

  pls_port_latch dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .intervalTick(intervalTick), .port0PinIn(pin0),
    .port1PinIn(pin1), .port0Drive(port0Drive), .port1Drive(port1Drive));
  pls_led_model led (.port0Drive(port0Drive), .port1Drive(port1Drive), .extEn(extEn),
    .extVal(extVal), .pin0(pin0), .pin1(pin1), .litMap(litMap));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t no ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
    apb(1'b0, a, 32'h0);
    cmp({er, rd}, {1'b0, 24'h0, e}, what);
  endtask

  // Outside source on the pins; it stays off wherever the block drives
  task automatic ext(input logic [15:0] en, input logic [15:0] v);
    @(posedge mclk);
    extEn <= en;
    extVal <= v;
  endtask

  // Pin sync and pad update both finish within three edges
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(OFS_P0_DIR, RST_DIR, "dir0 reset");
    rdc(OFS_P1_MODE, RST_ZERO, "mode1 reset");
    rdc(OFS_P0_ANA, RST_ZERO, "ana0 reset");
    rdc(OFS_P0_DATA, 8'hC0, "p0 pins at reset");
    cmp(port0Drive.oe, 8'h00, "oe at reset");
    apb(1'b1, 8'h2C, 32'hFF);
    cmp(er, 1'b1, "unmapped write");
    apb(1'b0, 8'h2C, 32'h0);
    cmp({er, rd}, {1'b1, 32'h0}, "unmapped read");
  endtask

  task automatic t_view();
    ext(16'h00FF, 16'h00A5);
    apb(1'b1, OFS_P0_DATA, 32'h3C);
    settle();
    rdc(OFS_P0_DATA, 8'hA5, "input reads pin");
    ext(16'h00F0, 16'h00A0);
    apb(1'b1, OFS_P0_DIR, 32'hF0);
    settle();
    rdc(OFS_P0_DATA, 8'hAC, "mixed view");
    cmp({port0Drive.oe, port0Drive.dout[3:0]}, {8'h0F, 4'hC}, "p0 pads");
    apb(1'b1, OFS_BITOP, 32'h10);
    rdc(OFS_P0_DATA, 8'hAD, "bit set view");
    ext(16'h0000, 16'h0000);
    apb(1'b1, OFS_P0_DIR, 32'h00);
    settle();
    cmp(port0Drive.dout, 8'hAD, "input pins into latch");
    apb(1'b1, OFS_BITOP, 32'h00);
    settle();
    cmp(port0Drive.dout, 8'hAC, "bit clear");
    apb(1'b1, OFS_BITOP, 32'h1F);
    apb(1'b1, OFS_P1_DIR, 32'h00);
    settle();
    cmp(port1Drive.dout, 8'hFF, "p1 pulled pins into latch");
    apb(1'b1, OFS_P1_DATA, 32'h00);
    settle();
    cmp({port1Drive.oe, port1Drive.dout}, 16'hFF00, "p1 rewritten");
  endtask

  task automatic t_analog();
    apb(1'b1, OFS_P1_DATA, 32'hFF);
    apb(1'b1, OFS_P1_ANA, 32'h01);
    settle();
    cmp(port1Drive.oe, 8'hFE, "analog pad off");
    rdc(OFS_P1_DATA, 8'hFE, "analog reads 0");
    apb(1'b1, OFS_P1_ANA, 32'h00);
    settle();
    cmp(port1Drive.oe, 8'hFF, "digital again");
  endtask

  task automatic t_drain();
    apb(1'b1, OFS_P0_DATA, 32'h45);
    apb(1'b1, OFS_P0_MODE, 32'hFF);
    settle();
    cmp({port0Drive.oe, port0Drive.dout}, 16'h853F, "p0 open drain");
    apb(1'b1, OFS_P1_DATA, 32'h45);
    apb(1'b1, OFS_P1_MODE, 32'hFF);
    settle();
    cmp({port1Drive.oe, port1Drive.dout}, 16'hFA40, "p1 open drain");
  endtask

  task automatic t_display();
    logic [7:0] pat [6];
    pat = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'hED};
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, OFS_PAT0 + 8'(4 * k), {24'h0, pat[k]});
    end
    apb(1'b1, OFS_DISP, 32'h01);
    for (int k = 0; k < 7; k++) begin
      @(posedge mclk);
      intervalTick <= 1'b1;
      @(posedge mclk);
      intervalTick <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      cmp(litMap, 48'(pat[k % 6]) << (8 * (k % 6)), "lit digit");
      rdc(OFS_SCAN, 8'(k % 6), "scan index");
    end
    // Switching the scan off must freeze the pads on the last digit shown
    apb(1'b1, OFS_DISP, 32'h00);
    rdc(OFS_DISP, 8'h00, "display off");
    @(posedge mclk);
    intervalTick <= 1'b1;
    @(posedge mclk);
    intervalTick <= 1'b0;
    settle();
    cmp(litMap, 48'(pat[0]), "scan stopped");
    rdc(OFS_SCAN, 8'(LAST_DIGIT), "idle digit");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    checks = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    intervalTick = 1'b0;
    extEn = 16'h0000;
    extVal = 16'h0000;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_view();
    t_analog();
    t_drain();
    t_display();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("[ERR] %0t timeout", $time);
    give_verdict();
  end
endmodule
